// ---- pkg/tppc_pkg.sv ----
// Package for the terminal page and pointer control block
package tppc_pkg;
  localparam int CFG_BYTES = 32;
  localparam logic [4:0] CFG_LAST = 5'h1f;
  localparam logic [4:0] CFG_FMT_IDX = 5'h00;
  localparam int FMT_LINES_BIT = 0;
  localparam int FMT_COLS_BIT = 1;
  localparam logic [4:0] LINES_SHORT = 5'h0c;
  localparam logic [4:0] LINES_LONG = 5'h18;
  localparam logic [6:0] COLS_SHORT = 7'h28;
  localparam logic [6:0] COLS_LONG = 7'h50;
  localparam logic [6:0] STAT_LEN = 7'h50;
  localparam logic [6:0] STAT_ERR_LEN = 7'h10;
  localparam logic [6:0] STAT_MSG_LEN = 7'h34;
  localparam logic [6:0] STAT_PAGE_POS = 7'h49;
  localparam logic [4:0] STAT_ROW = 5'h18;
  localparam int PAGE_W = 3;
  localparam logic [PAGE_W-1:0] PAGE_MAX = 3'h7;
  localparam logic [7:0] NV_ROM_RESET = 8'h00;

  typedef enum logic [3:0] {
    TPPC_CMD_NONE, TPPC_CMD_UP, TPPC_CMD_DOWN, TPPC_CMD_LEFT, TPPC_CMD_RIGHT,
    TPPC_CMD_TO_PTR, TPPC_CMD_PG_ADV, TPPC_CMD_PG_BACK, TPPC_CMD_SCR_UP,
    TPPC_CMD_SCR_DN, TPPC_CMD_PG_SEL, TPPC_CMD_XMT, TPPC_CMD_RCV,
    TPPC_CMD_FMT, TPPC_CMD_NEG, TPPC_CMD_MSG
  } tppc_cmd_t;

  typedef struct packed {
    logic [PAGE_W-1:0] page;
    logic [4:0] row;
    logic [6:0] col;
  } tppc_pos_t;

  typedef struct packed {
    logic valid;
    tppc_cmd_t code;
    logic [7:0] arg;
    logic fromLine;
  } tppc_req_t;

  typedef enum {TPPC_LOAD, TPPC_RUN} tppc_phase_t;

  typedef struct packed {
    tppc_phase_t phase;
    logic [4:0] loadIdx;
    logic [7:0] fmtCfg;
    logic fmtOvr;
    logic [1:0] fmtTmp;
    logic negVideo;
    tppc_pos_t cursor;
    tppc_pos_t pointer;
    logic [7:0] msgLeft;
    logic [5:0] msgIdx;
  } tppc_state_t;
endpackage

// ---- design/tppc_core.sv ----
// Terminal cursor, data-comm pointer, format and status-line control
// Functional notes
// - Power-on copies the 32-byte stored image into writable active configuration.
// - Configuration edits are lost; reset reloads the stored image.
// - Escape commands of two to five characters arrive as one decoded code.
// - Same-page cursor moves move the pointer identically; the code sets the pointer to the new cursor position.
// - Line data writes at pointer page, keyboard writes at cursor page.
// - Cursor-to-pointer command puts cursor at pointer position.
// - Page advance and back move only the cursor.
// - Scroll up on last line of pointer page moves cursor to next page.
// - Scroll down on first line of pointer page moves cursor back a page.
// - Page select puts pointer home on the named page.
// - Transmit key sets pointer to cursor.
// - Receive key sets pointer to cursor.
// - Configuration picks 12/24 lines, 40/80 columns; commands override temporarily.
// - An 80-character status line occupies screen row 24 (the 25th line).
// - Status positions 0-15 errors, 16-67 remote messages.
// - Last seven status positions show the cursor page number.
// - Message write gives start address, byte count, then up to 52 characters; the code takes only the count and always starts at position 16.
// - Power-on is normal video; only commands toggle negative video.
//
`timescale 1ns/100ps
`default_nettype none
module tppc_core
  import tppc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  output logic [4:0] nvAddr,
  input wire logic [7:0] nvData,
  output logic cfgWe,
  output logic [4:0] cfgWAddr,
  output logic [7:0] cfgWData,
  output logic cfgReady,
  input wire tppc_req_t req,
  input wire logic [7:0] msgChar,
  input wire logic msgCharValid,
  input wire logic lineWrite,
  input wire logic keyWrite,
  output tppc_pos_t lineWrPos,
  output tppc_pos_t keyWrPos,
  output logic lineWrEn,
  output logic keyWrEn,
  output tppc_pos_t cursorPos,
  output tppc_pos_t pointerPos,
  output logic [4:0] fmtLines,
  output logic [6:0] fmtCols,
  output logic negVideo,
  output logic statWe,
  output logic [6:0] statAddr,
  output logic [7:0] statData,
  output logic [4:0] statRow,
  output logic [PAGE_W-1:0] statPage
);
  tppc_state_t s_q, s_d;
  logic [7:0] cfgRd;
  logic [6:0] statAddrQ;
  logic statWeQ;
  logic [7:0] statDataQ;

  function automatic logic [4:0] linesOf(input logic [1:0] f);
    return f[FMT_LINES_BIT] ? LINES_LONG : LINES_SHORT;
  endfunction

  function automatic logic [6:0] colsOf(input logic [1:0] f);
    return f[FMT_COLS_BIT] ? COLS_LONG : COLS_SHORT;
  endfunction

  // Active format: a command override wins over the stored byte
  logic [1:0] fmtAct;
  logic [4:0] lastRow;
  logic [6:0] lastCol;
  logic samePage;
  assign fmtAct = s_q.fmtOvr ? s_q.fmtTmp : s_q.fmtCfg[1:0];
  assign lastRow = linesOf(fmtAct) - 5'h01;
  assign lastCol = colsOf(fmtAct) - 7'h01;
  assign samePage = s_q.cursor.page == s_q.pointer.page;

  always_comb begin
    tppc_pos_t nc;
    logic run;
    s_d = s_q;
    nc = s_q.cursor;
    run = s_q.phase == TPPC_RUN;
    cfgRd = nvData;
    statWeQ = 1'b0;
    statAddrQ = 7'h00;
    statDataQ = 8'h00;
    // Load walks the image once, one byte a cycle
    unique case (s_q.phase)
      TPPC_LOAD: begin
        s_d.loadIdx = s_q.loadIdx + 5'h01;
        if (s_q.loadIdx == CFG_FMT_IDX) begin
          s_d.fmtCfg = nvData;
        end
        if (s_q.loadIdx == CFG_LAST) begin
          s_d.phase = TPPC_RUN;
        end
      end
      TPPC_RUN: begin
        if (req.valid) begin
          unique case (req.code)
            // Moves stop at the field edge; no wrap to the next line
            TPPC_CMD_UP: begin
              if (s_q.cursor.row != 5'h00) begin
                nc.row = s_q.cursor.row - 5'h01;
              end
            end
            TPPC_CMD_DOWN: begin
              if (s_q.cursor.row < lastRow) begin
                nc.row = s_q.cursor.row + 5'h01;
              end
            end
            TPPC_CMD_LEFT: begin
              if (s_q.cursor.col != 7'h00) begin
                nc.col = s_q.cursor.col - 7'h01;
              end
            end
            TPPC_CMD_RIGHT: begin
              if (s_q.cursor.col < lastCol) begin
                nc.col = s_q.cursor.col + 7'h01;
              end
            end
            TPPC_CMD_TO_PTR: begin
              nc = s_q.pointer;
            end
            // Page steps leave the pointer where line data lands
            TPPC_CMD_PG_ADV: begin
              if (s_q.cursor.page != PAGE_MAX) begin
                nc.page = s_q.cursor.page + 3'h1;
              end
            end
            TPPC_CMD_PG_BACK: begin
              if (s_q.cursor.page != 3'h0) begin
                nc.page = s_q.cursor.page - 3'h1;
              end
            end
            // Scrolls step pages only from the edge rows of the pointer's page
            TPPC_CMD_SCR_UP: begin
              if (samePage && s_q.cursor.row == lastRow && s_q.cursor.page != PAGE_MAX) begin
                nc.page = s_q.cursor.page + 3'h1;
                nc.row = 5'h00;
              end
            end
            TPPC_CMD_SCR_DN: begin
              if (samePage && s_q.cursor.row == 5'h00 && s_q.cursor.page != 3'h0) begin
                nc.page = s_q.cursor.page - 3'h1;
                nc.row = lastRow;
              end
            end
            TPPC_CMD_PG_SEL: begin
              s_d.pointer.page = req.arg[PAGE_W-1:0];
              s_d.pointer.row = 5'h00;
              s_d.pointer.col = 7'h00;
            end
            TPPC_CMD_XMT: begin
              s_d.pointer = s_q.cursor;
            end
            TPPC_CMD_RCV: begin
              s_d.pointer = s_q.cursor;
            end
            // Override lasts until reset reloads the stored format
            TPPC_CMD_FMT: begin
              s_d.fmtOvr = 1'b1;
              s_d.fmtTmp = req.arg[1:0];
            end
            TPPC_CMD_NEG: begin
              s_d.negVideo = ~s_q.negVideo;
            end
            TPPC_CMD_MSG: begin
              // Writes always start at the first message cell; count caps at 52
              s_d.msgIdx = 6'h00;
              s_d.msgLeft = (req.arg > 8'h34) ? 8'h34 : req.arg;
            end
            default: ;
          endcase
          s_d.cursor = nc;
          // Plain in-page moves carry the pointer along
          if (samePage && req.code inside {TPPC_CMD_UP, TPPC_CMD_DOWN,
              TPPC_CMD_LEFT, TPPC_CMD_RIGHT}) begin
            s_d.pointer = nc;
          end
        end
        // One status cell per character; characters past the count are dropped
        if (msgCharValid && s_q.msgLeft != 8'h00) begin
          statWeQ = 1'b1;
          statAddrQ = STAT_ERR_LEN + {1'b0, s_q.msgIdx};
          statDataQ = msgChar;
          s_d.msgIdx = s_q.msgIdx + 6'h01;
          s_d.msgLeft = s_q.msgLeft - 8'h01;
        end
      end
    endcase
    if (!run) begin
      statWeQ = 1'b0;
    end
  end

  // Status writes are registered so the screen side sees settled data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      s_q.phase <= TPPC_LOAD;
      s_q.loadIdx <= 5'h00;
      s_q.fmtCfg <= NV_ROM_RESET;
      s_q.fmtOvr <= 1'b0;
      s_q.fmtTmp <= 2'h0;
      s_q.negVideo <= 1'b0;
      s_q.cursor <= '0;
      s_q.pointer <= '0;
      s_q.msgLeft <= 8'h00;
      s_q.msgIdx <= 6'h00;
      statWe <= 1'b0;
      statAddr <= 7'h00;
      statData <= 8'h00;
      cfgWe <= 1'b0;
      cfgWAddr <= 5'h00;
      cfgWData <= 8'h00;
    end else begin
      s_q <= s_d;
      statWe <= statWeQ;
      statAddr <= statAddrQ;
      statData <= statDataQ;
      cfgWe <= s_q.phase == TPPC_LOAD;
      cfgWAddr <= s_q.loadIdx;
      cfgWData <= cfgRd;
    end
  end

  // Line data lands at the pointer, keys at the cursor
  assign nvAddr = s_q.loadIdx;
  assign cfgReady = s_q.phase == TPPC_RUN;
  assign cursorPos = s_q.cursor;
  assign pointerPos = s_q.pointer;
  assign lineWrPos = s_q.pointer;
  assign keyWrPos = s_q.cursor;
  assign lineWrEn = lineWrite && cfgReady;
  assign keyWrEn = keyWrite && cfgReady;
  assign fmtLines = linesOf(fmtAct);
  assign fmtCols = colsOf(fmtAct);
  assign negVideo = s_q.negVideo;
  assign statRow = STAT_ROW;
  assign statPage = s_q.cursor.page;

  // Load and configuration copy
  a_load_len: assert property (@(posedge clk_sys) disable iff (rst)
    $rose(cfgReady) |-> $past(cfgWe) && $past(cfgWAddr) == 5'h1e)
    else $error("load length");

  a_load_data: assert property (@(posedge clk_sys) disable iff (rst)
    cfgWe |-> cfgWAddr == $past(nvAddr) && cfgWData == $past(nvData))
    else $error("active copy differs from image");

  a_load_quiet: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && $past(cfgReady) |-> !cfgWe)
    else $error("copy written after load");

  // Nothing reaches the screen until the load phase ends and cfgReady rises
  a_load_idle: assert property (@(posedge clk_sys) disable iff (rst)
    !cfgReady |-> !statWe && !lineWrEn && !keyWrEn)
    else $error("write during load");

  // Pointer and cursor moves
  a_same_page: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && cursorPos == pointerPos &&
    req.code inside {TPPC_CMD_UP, TPPC_CMD_DOWN, TPPC_CMD_LEFT, TPPC_CMD_RIGHT}
    |=> cursorPos == pointerPos)
    else $error("pointer lost alignment");

  a_line_key: assert property (@(posedge clk_sys) disable iff (rst)
    lineWrEn && keyWrEn |-> lineWrPos == pointerPos && keyWrPos == cursorPos)
    else $error("write page mixed up");

  a_to_ptr: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_TO_PTR |=> cursorPos == $past(pointerPos))
    else $error("cursor not at pointer");

  a_page_adv: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code inside {TPPC_CMD_PG_ADV, TPPC_CMD_PG_BACK}
    |=> $stable(pointerPos))
    else $error("pointer moved on page step");

  a_page_edge: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_PG_ADV && cursorPos.page == PAGE_MAX
    |=> $stable(cursorPos))
    else $error("page advance wrapped");

  a_back_edge: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_PG_BACK && cursorPos.page == 3'h0
    |=> $stable(cursorPos))
    else $error("page back wrapped");

  a_row_edge: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_DOWN && cursorPos.row == lastRow
    |=> $stable(cursorPos))
    else $error("cursor left the working field");

  a_scroll_up: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_SCR_UP |=> $stable(pointerPos))
    else $error("pointer moved on scroll");

  a_scroll_next: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_SCR_UP && samePage &&
    cursorPos.row == lastRow && cursorPos.page != PAGE_MAX
    |=> cursorPos.page == $past(cursorPos.page) + 3'h1)
    else $error("scroll up missed next page");

  a_scroll_dn: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_SCR_DN |=> $stable(pointerPos))
    else $error("pointer moved on scroll down");

  a_scroll_prev: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_SCR_DN && samePage &&
    cursorPos.row == 5'h00 && cursorPos.page != 3'h0
    |=> cursorPos.page == $past(cursorPos.page) - 3'h1)
    else $error("scroll down missed previous page");

  a_page_sel: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_PG_SEL |=> pointerPos.row == 5'h00 &&
    pointerPos.col == 7'h00 && pointerPos.page == $past(req.arg[PAGE_W-1:0]))
    else $error("page select not home");

  a_xmt_ptr: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_XMT |=> pointerPos == $past(cursorPos))
    else $error("transmit pointer wrong");

  a_rcv_ptr: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_RCV |=> pointerPos == $past(cursorPos))
    else $error("receive pointer wrong");

  // Format, status line and video
  a_fmt_ovr: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_FMT
    |=> fmtLines == ($past(req.arg[FMT_LINES_BIT]) ? LINES_LONG : LINES_SHORT) &&
    fmtCols == ($past(req.arg[FMT_COLS_BIT]) ? COLS_LONG : COLS_SHORT))
    else $error("format override not applied");

  a_fmt_hold: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && $past(cfgReady) && !($past(req.valid) && $past(req.code) == TPPC_CMD_FMT)
    |-> $stable(fmtLines) && $stable(fmtCols))
    else $error("format changed without command");

  a_msg_range: assert property (@(posedge clk_sys) disable iff (rst)
    statWe |-> statAddr >= 7'h10 && statAddr < 7'h44)
    else $error("message out of field");

  a_msg_cap: assert property (@(posedge clk_sys) disable iff (rst)
    cfgReady && req.valid && req.code == TPPC_CMD_MSG |=> s_q.msgLeft <= 8'h34)
    else $error("message count above field");

  a_msg_char: assert property (@(posedge clk_sys) disable iff (rst)
    statWe |-> $past(msgCharValid) && statData == $past(msgChar))
    else $error("status write without character");

  a_stat_page: assert property (@(posedge clk_sys) disable iff (rst)
    statPage == cursorPos.page && statRow == STAT_ROW)
    else $error("status page number wrong");

  a_neg_video: assert property (@(posedge clk_sys) disable iff (rst)
    $changed(negVideo) |-> $past(req.valid) && $past(req.code) == TPPC_CMD_NEG)
    else $error("video polarity changed alone");

  a_neg_reset: assert property (@(posedge clk_sys)
    $past(rst) |-> !negVideo)
    else $error("negative video survived reset");

  a_fmt_reset: assert property (@(posedge clk_sys)
    $past(rst) |-> !s_q.fmtOvr)
    else $error("override survived reset");

  c_load: cover property (@(posedge clk_sys) $rose(cfgReady));
  c_scroll: cover property (@(posedge clk_sys) cfgReady && req.valid &&
    req.code == TPPC_CMD_SCR_UP ##1 !samePage);
  c_msg: cover property (@(posedge clk_sys) statWe ##1 statWe);
  c_fmt: cover property (@(posedge clk_sys) s_q.fmtOvr);
  c_page_sel: cover property (@(posedge clk_sys) cfgReady && req.valid &&
    req.code == TPPC_CMD_PG_SEL ##1 !samePage);
endmodule
`default_nettype wire

// ---- verif/tppc_nv_model.sv ----
// Stored configuration image with a monitor on the active copy writes
`timescale 1ns/100ps
`default_nettype none
module tppc_nv_model (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic [4:0] nvAddr,
  output logic [7:0] nvData,
  input wire logic cfgWe,
  input wire logic [4:0] cfgWAddr,
  input wire logic [7:0] cfgWData,
  output var int wrCount,
  output var int badCount
);
  // Byte 0 selects 12 lines of 80 columns; the others only need to differ
  function automatic logic [7:0] img(input logic [4:0] a);
    return {3'h0, a} ^ 8'h02;
  endfunction
  assign nvData = img(nvAddr);
  // Counts restart on every reset, so a second load is checked whole
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      wrCount <= 0;
      badCount <= 0;
    end else if (cfgWe) begin
      wrCount <= wrCount + 1;
      badCount <= badCount + int'(cfgWData !== img(cfgWAddr));
    end
  end
endmodule
`default_nettype wire

// ---- verif/tb_top.sv ----
// Self-checking bench for the page and pointer control block
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import tppc_pkg::*;
;
  logic clk_sys, rst, cfgWe, cfgReady, msgCharValid, lineWrite, keyWrite;
  logic lineWrEn, keyWrEn, negVideo, statWe;
  logic [4:0] nvAddr, cfgWAddr, fmtLines, statRow;
  logic [7:0] nvData, cfgWData, msgChar, statData;
  logic [6:0] fmtCols, statAddr;
  logic [PAGE_W-1:0] statPage;
  tppc_req_t req;
  tppc_pos_t lineWrPos, keyWrPos, cursorPos, pointerPos;
  int wrCount, badCount, errors, compares;
  tppc_core dut (.clk_sys(clk_sys), .rst(rst), .nvAddr(nvAddr), .nvData(nvData),
    .cfgWe(cfgWe), .cfgWAddr(cfgWAddr), .cfgWData(cfgWData), .cfgReady(cfgReady),
    .req(req), .msgChar(msgChar), .msgCharValid(msgCharValid), .lineWrite(lineWrite),
    .keyWrite(keyWrite), .lineWrPos(lineWrPos), .keyWrPos(keyWrPos), .lineWrEn(lineWrEn),
    .keyWrEn(keyWrEn), .cursorPos(cursorPos), .pointerPos(pointerPos), .fmtLines(fmtLines),
    .fmtCols(fmtCols), .negVideo(negVideo), .statWe(statWe), .statAddr(statAddr),
    .statData(statData), .statRow(statRow), .statPage(statPage));
  tppc_nv_model nv (.clk_sys(clk_sys), .rst(rst), .nvAddr(nvAddr), .nvData(nvData),
    .cfgWe(cfgWe), .cfgWAddr(cfgWAddr), .cfgWData(cfgWData), .wrCount(wrCount),
    .badCount(badCount));
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function automatic tppc_pos_t pos(input int p, input int r, input int c);
    return '{PAGE_W'(p), 5'(r), 7'(c)};
  endfunction
  task automatic doReset();
    int n;
    n = 0;
    rst <= 1'b1;
    repeat (8) @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    while (cfgReady !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n > 40) begin
        errors++;
        wrap_up();
      end
    end
    // The last copy write is registered, so it lands one edge after ready
    @(posedge clk_sys);
    #1;
  endtask
  task automatic cmd(input tppc_cmd_t c, input logic [7:0] a);
    @(posedge clk_sys);
    req <= '{1'b1, c, a, c inside {TPPC_CMD_PG_SEL, TPPC_CMD_MSG}};
    @(posedge clk_sys);
    req.valid <= 1'b0;
    #1;
  endtask
  initial begin
    rst = 1'b1;
    req = '0;
    msgChar = 8'h00;
    msgCharValid = 1'b0;
    lineWrite = 1'b0;
    keyWrite = 1'b0;
    doReset();
    chk(wrCount, 32);
    chk(badCount, 0);
    // Image byte 0 is 8'h02: short lines, long columns
    chk(fmtLines, LINES_SHORT);
    chk(fmtCols, COLS_LONG);
    chk(negVideo, 1'b0);
    chk(statRow, STAT_ROW);
    cmd(TPPC_CMD_RIGHT, 8'h00);
    cmd(TPPC_CMD_DOWN, 8'h00);
    chk(pointerPos, pos(0, 1, 1));
    cmd(TPPC_CMD_PG_ADV, 8'h00);
    chk(cursorPos, pos(1, 1, 1));
    chk(pointerPos, pos(0, 1, 1));
    chk(statPage, 1);
    @(posedge clk_sys);
    lineWrite <= 1'b1;
    keyWrite <= 1'b1;
    #1;
    chk({lineWrEn, keyWrEn}, 2'b11);
    chk(lineWrPos, pos(0, 1, 1));
    chk(keyWrPos, pos(1, 1, 1));
    @(posedge clk_sys);
    lineWrite <= 1'b0;
    keyWrite <= 1'b0;
    cmd(TPPC_CMD_RIGHT, 8'h00);
    chk(pointerPos, pos(0, 1, 1));
    cmd(TPPC_CMD_TO_PTR, 8'h00);
    chk(cursorPos, pos(0, 1, 1));
    cmd(TPPC_CMD_PG_ADV, 8'h00);
    cmd(TPPC_CMD_XMT, 8'h00);
    chk(pointerPos, pos(1, 1, 1));
    cmd(TPPC_CMD_PG_ADV, 8'h00);
    cmd(TPPC_CMD_RCV, 8'h00);
    chk(pointerPos, pos(2, 1, 1));
    cmd(TPPC_CMD_PG_SEL, 8'h03);
    chk(pointerPos, pos(3, 0, 0));
    cmd(TPPC_CMD_TO_PTR, 8'h00);
    chk(cursorPos, pos(3, 0, 0));
    cmd(TPPC_CMD_SCR_DN, 8'h00);
    chk(cursorPos.page, 2);
    chk(pointerPos, pos(3, 0, 0));
    cmd(TPPC_CMD_TO_PTR, 8'h00);
    // One move more than reaching row 11 needs, to press on the bottom edge
    repeat (12) cmd(TPPC_CMD_DOWN, 8'h00);
    chk(pointerPos, pos(3, 11, 0));
    cmd(TPPC_CMD_SCR_UP, 8'h00);
    chk(cursorPos.page, 4);
    chk(pointerPos, pos(3, 11, 0));
    cmd(TPPC_CMD_MSG, 8'h02);
    for (int i = 0; i < 3; i++) begin
      @(posedge clk_sys);
      msgChar <= 8'(8'h41 + i);
      msgCharValid <= 1'b1;
      @(posedge clk_sys);
      msgCharValid <= 1'b0;
      #1;
      chk(statWe, i < 2);
      if (i < 2) chk({statAddr, statData}, {7'(STAT_ERR_LEN + i), 8'(8'h41 + i)});
    end
    cmd(TPPC_CMD_FMT, 8'h01);
    chk({fmtLines, fmtCols}, {LINES_LONG, COLS_SHORT});
    cmd(TPPC_CMD_NEG, 8'h00);
    chk(negVideo, 1'b1);
    cmd(TPPC_CMD_NEG, 8'h00);
    chk(negVideo, 1'b0);
    cmd(TPPC_CMD_NEG, 8'h00);
    doReset();
    chk(wrCount, 32);
    chk(badCount, 0);
    chk({fmtLines, fmtCols}, {LINES_SHORT, COLS_LONG});
    chk(negVideo, 1'b0);
    wrap_up();
  end
endmodule
`default_nettype wire
